/* File: hdl/overcurrent_status_flags.sv */
// Latched overcurrent flags of bridges 1 to 8, their command decode and the summary fault bit.
//
// Overview of operation
// - The summary fault bit is read only and is the OR of every overcurrent and open-load flag.
// - Once all those flags are zero the summary fault bit drops by itself without any write.
// - An overcurrent on a switch sets its flag to 1, which holds until cleared and turns it off.
// - All overcurrent flags are 0 after reset and can be read and cleared by the controller.
// - The first byte holds bridges 4 down to 1, high side above low side, bit 0 is bridge 1 low.
// - The second byte holds bridges 8 down to 5, high side above low side, bit 0 is bridge 5 low.
// - The first byte is selected by a command byte of kind bit, 101, 10, access type bit, 1.
// - The second byte is selected by a command byte of kind bit, 011, 10, access type bit, 1.
`timescale 1ns/100ps
module overcurrent_status_flags
  import oc_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [NUM_BRIDGES-1:0] oc_high_side_raw,
  input wire logic [NUM_BRIDGES-1:0] oc_low_side_raw,
  input wire logic [EXT_FLAGS-1:0] other_fault_flags,
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  output rd_s rd_q,
  output logic [NUM_FLAGS-1:0] switch_off_q,
  output logic summary_fault_bit_q
);

  logic [NUM_FLAGS-1:0] oc_raw_vec;
  logic [NUM_FLAGS-1:0] oc_vec_s;
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flags_d;
  logic [NUM_FLAGS-1:0] clr_mask;
  logic frame_ok;
  logic hit_first;
  logic hit_second;
  logic hit_any;
  logic clr_first;
  logic clr_second;
  logic summary_d;
  rd_s rd_d;

  // Pair each bridge into two adjacent bits, high side above low side.
  for (genvar b = 0; b < NUM_BRIDGES; b++) begin : g_pack
    assign oc_raw_vec[2*b+HIGH_SIDE_POS] = oc_high_side_raw[b];
    assign oc_raw_vec[2*b+LOW_SIDE_POS] = oc_low_side_raw[b];
  end

  sync_bits #(
    .WIDTH(NUM_FLAGS)
  ) u_oc_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(oc_raw_vec),
    .sync_out(oc_vec_s)
  );

  // Command decode; the access type bit is accepted at either value.
  assign frame_ok = (cmd.fixed == CMD_FIXED_BITS) && (cmd.tail == CMD_TAIL_BIT);
  assign hit_first = cmd_valid && frame_ok && (cmd.addr == ADDR_FIRST_BYTE);
  assign hit_second = cmd_valid && frame_ok && (cmd.addr == ADDR_SECOND_BYTE);
  assign hit_any = hit_first || hit_second;
  assign clr_first = hit_first && (cmd.command_kind_bit == CMD_KIND_CLEAR);
  assign clr_second = hit_second && (cmd.command_kind_bit == CMD_KIND_CLEAR);

  assign clr_mask = {{BYTE_W{clr_second}}, {BYTE_W{clr_first}}};

  // A detection in the clearing cycle keeps its flag set.
  assign flags_d = (flags_q & ~clr_mask) | oc_vec_s;

  // The summary has no write path; it follows the flags alone.
  assign summary_d = (|flags_q) || (|other_fault_flags);

  // The read returns the byte as it stood before any clear.
  assign rd_d.valid = hit_any;
  assign rd_d.data = hit_first ? flags_q[FIRST_BYTE_LSB +: BYTE_W] :
                     hit_second ? flags_q[SECOND_BYTE_LSB +: BYTE_W] :
                     RD_DATA_RESET;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RESET;
      switch_off_q <= FLAGS_RESET;
      summary_fault_bit_q <= 1'h0;
      rd_q <= '0;
    end else begin
      flags_q <= flags_d;
      switch_off_q <= flags_d;
      summary_fault_bit_q <= summary_d;
      rd_q <= rd_d;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_all_quiet;
    (flags_q == FLAGS_RESET) && (other_fault_flags == '0);
  endsequence

  sequence s_first_read;
    hit_first;
  endsequence

  sequence s_second_read;
    hit_second;
  endsequence

  // A plain read leaves the addressed byte alone apart from new detections.
  sequence s_first_peek;
    hit_first && !clr_first;
  endsequence

  sequence s_second_peek;
    hit_second && !clr_second;
  endsequence

  // A clear while a detection still stands must not lose that detection.
  sequence s_first_clash;
    clr_first && (|oc_vec_s[7:0]);
  endsequence

  sequence s_second_clash;
    clr_second && (|oc_vec_s[15:8]);
  endsequence

  a_set_latches: assert property (
    1'h1 |=> ((flags_q & $past(oc_vec_s)) == $past(oc_vec_s)))
    else $error("Detected overcurrent did not set its flag.");

  a_flag_holds: assert property (
    !(clr_first || clr_second) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("Flag dropped without a clear.");

  a_clear_first: assert property (
    clr_first |=> (flags_q[7:0] == $past(oc_vec_s[7:0])))
    else $error("First byte clear left stale flags.");

  a_clear_second: assert property (
    clr_second |=> (flags_q[15:8] == $past(oc_vec_s[15:8])))
    else $error("Second byte clear left stale flags.");

  a_switch_off: assert property (
    oc_vec_s[0] |=> switch_off_q[0])
    else $error("Switch not turned off after overcurrent.");

  a_switch_holds: assert property (
    (switch_off_q[0] && !clr_first) |=> switch_off_q[0])
    else $error("Switch turned back on without a clear.");

  a_summary_or: assert property (
    summary_fault_bit_q == $past((|flags_q) || (|other_fault_flags)))
    else $error("Summary bit is not the OR of the flags.");

  a_summary_drop: assert property (
    s_all_quiet |=> !summary_fault_bit_q)
    else $error("Summary bit stayed set with all flags clear.");

  a_read_first: assert property (
    s_first_read |=> rd_q.valid && (rd_q.data == $past(flags_q[7:0])))
    else $error("First byte read returned wrong data.");

  a_read_second: assert property (
    s_second_read |=> rd_q.valid && (rd_q.data == $past(flags_q[15:8])))
    else $error("Second byte read returned wrong data.");

  a_miss_silent: assert property (
    (cmd_valid && !hit_any) |=> !rd_q.valid)
    else $error("Unmatched command produced a read answer.");

  a_valid_cause: assert property (
    rd_q.valid |-> $past(hit_any))
    else $error("Read answer appeared without a matching command.");

  a_peek_first: assert property (
    s_first_peek |=> (flags_q[7:0] == ($past(flags_q[7:0]) | $past(oc_vec_s[7:0]))))
    else $error("Plain read of the first byte changed its flags.");

  a_peek_second: assert property (
    s_second_peek |=> (flags_q[15:8] == ($past(flags_q[15:8]) | $past(oc_vec_s[15:8]))))
    else $error("Plain read of the second byte changed its flags.");

  a_clear_spares_high: assert property (
    clr_first |=> (flags_q[15:8] == ($past(flags_q[15:8]) | $past(oc_vec_s[15:8]))))
    else $error("First byte clear disturbed the second byte.");

  a_clear_spares_low: assert property (
    clr_second |=> (flags_q[7:0] == ($past(flags_q[7:0]) | $past(oc_vec_s[7:0]))))
    else $error("Second byte clear disturbed the first byte.");

  a_set_beats_first: assert property (
    s_first_clash |=> ((flags_q[7:0] & $past(oc_vec_s[7:0])) == $past(oc_vec_s[7:0])))
    else $error("Clear of the first byte lost a standing detection.");

  a_set_beats_second: assert property (
    s_second_clash |=> ((flags_q[15:8] & $past(oc_vec_s[15:8])) == $past(oc_vec_s[15:8])))
    else $error("Clear of the second byte lost a standing detection.");

  a_summary_flags: assert property (
    (|flags_q) |=> summary_fault_bit_q)
    else $error("Summary bit missed a latched overcurrent flag.");

  a_summary_other: assert property (
    (|other_fault_flags) |=> summary_fault_bit_q)
    else $error("Summary bit missed an open-load or other fault.");

  a_summary_no_write: assert property (
    (hit_any && s_all_quiet) |=> !summary_fault_bit_q)
    else $error("A command raised the summary bit with no fault.");

  a_miss_keeps: assert property (
    (cmd_valid && !hit_any) |=> (flags_q == ($past(flags_q) | $past(oc_vec_s))))
    else $error("Unmatched command changed the flags.");

endmodule : overcurrent_status_flags

/* File: hdl/oc_status_pkg.sv */
// Package with command codes, bit layouts and reset values of the overcurrent status bank.
package oc_status_pkg;

  localparam int NUM_BRIDGES = 8;
  localparam int NUM_FLAGS = 16;
  localparam int EXT_FLAGS = 32;
  localparam int BYTE_W = 8;

  localparam logic [2:0] ADDR_FIRST_BYTE = 3'h5;
  localparam logic [2:0] ADDR_SECOND_BYTE = 3'h3;
  localparam logic [1:0] CMD_FIXED_BITS = 2'h2;
  localparam logic CMD_TAIL_BIT = 1'h1;
  localparam logic CMD_KIND_CLEAR = 1'h1;

  localparam int HIGH_SIDE_POS = 1;
  localparam int LOW_SIDE_POS = 0;
  localparam int FIRST_BYTE_LSB = 0;
  localparam int SECOND_BYTE_LSB = 8;

  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [7:0] RD_DATA_RESET = 8'h00;

  // Command byte as it arrives, MSB first.
  typedef struct packed {
    logic command_kind_bit;
    logic [2:0] addr;
    logic [1:0] fixed;
    logic access_type_bit;
    logic tail;
  } cmd_s;

  // Read answer handed back to the serial logic.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rd_s;

endpackage : oc_status_pkg

/* File: hdl/sync_bits.sv */
// Two flip-flop synchroniser for a vector of independent level inputs.
`timescale 1ns/100ps
module sync_bits #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : sync_bits

/* File: sim/oc_host_model.sv */
// Host controller model that presents one command byte per request.
`timescale 1ns/100ps
module oc_host_model
  import oc_status_pkg::*;
(
  input wire logic req,
  input wire cmd_s req_cmd,
  output logic cmd_valid,
  output cmd_s cmd
);
  assign cmd_valid = req;
  assign cmd = req_cmd;
endmodule : oc_host_model

/* File: sim/tb_overcurrent_status_flags.sv */
// Self-checking bench for the overcurrent status flag bank.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module tb_overcurrent_status_flags
  import oc_status_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n, req, cmd_valid, summary_fault_bit_q;
  logic [7:0] hs, ls;
  logic [31:0] oth;
  cmd_s req_cmd, cmd;
  rd_s rd_q;
  logic [15:0] switch_off_q;
  int n_fail = 0;
  int compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  oc_host_model host_u (.req(req), .req_cmd(req_cmd), .cmd_valid(cmd_valid), .cmd(cmd));
  overcurrent_status_flags dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .oc_high_side_raw(hs), .oc_low_side_raw(ls), .other_fault_flags(oth),
    .cmd_valid(cmd_valid), .cmd(cmd), .rd_q(rd_q), .switch_off_q(switch_off_q),
    .summary_fault_bit_q(summary_fault_bit_q));
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Idle command lines carry the inverse of the last byte, never a stale copy.
  task automatic send(input logic k, input logic [2:0] a, input logic [1:0] f,
                      input logic v, input logic [7:0] d);
    @(negedge sys_clk);
    req = 1'b1;
    req_cmd = cmd_s'{k, a, f, 1'b0, CMD_TAIL_BIT};
    @(negedge sys_clk);
    req = 1'b0;
    req_cmd = ~req_cmd;
    `CHK(rd_q.valid, v)
    `CHK(rd_q.data, d)
  endtask : send
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    hs = 8'h00;
    ls = 8'h00;
    oth = 32'h0;
    req = 1'b0;
    req_cmd = 8'h00;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'b1;
    `CHK(switch_off_q, FLAGS_RESET)
    send(1'b0, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h00);
    send(1'b0, ADDR_SECOND_BYTE, CMD_FIXED_BITS, 1'b1, 8'h00);
    @(negedge sys_clk);
    hs = 8'h08;
    ls = 8'h10;
    repeat (2) @(negedge sys_clk);
    hs = 8'h00;
    ls = 8'h00;
    repeat (4) @(negedge sys_clk);
    `CHK(switch_off_q, 16'h0180)
    `CHK(summary_fault_bit_q, 1'b1)
    send(1'b0, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h80);
    send(1'b0, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h80);
    send(1'b0, ADDR_SECOND_BYTE, CMD_FIXED_BITS, 1'b1, 8'h01);
    send(1'b0, 3'h0, CMD_FIXED_BITS, 1'b0, 8'h00);
    send(1'b1, ADDR_FIRST_BYTE, 2'h1, 1'b0, 8'h00);
    `CHK(switch_off_q, 16'h0180)
    send(1'b1, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h80);
    send(1'b1, ADDR_SECOND_BYTE, CMD_FIXED_BITS, 1'b1, 8'h01);
    send(1'b0, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h00);
    send(1'b0, ADDR_SECOND_BYTE, CMD_FIXED_BITS, 1'b1, 8'h00);
    `CHK(switch_off_q, 16'h0000)
    `CHK(summary_fault_bit_q, 1'b0)
    oth = 32'h0001_0000;
    repeat (2) @(negedge sys_clk);
    `CHK(summary_fault_bit_q, 1'b1)
    oth = 32'h0;
    repeat (2) @(negedge sys_clk);
    `CHK(summary_fault_bit_q, 1'b0)
    hs = 8'h01;
    repeat (4) @(negedge sys_clk);
    send(1'b1, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h02);
    hs = 8'h00;
    repeat (4) @(negedge sys_clk);
    send(1'b0, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h02);
    `CHK(switch_off_q, 16'h0002)
    send(1'b1, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h02);
    send(1'b0, ADDR_FIRST_BYTE, CMD_FIXED_BITS, 1'b1, 8'h00);
    `CHK(summary_fault_bit_q, 1'b0)
    end_of_test();
  end
endmodule : tb_overcurrent_status_flags
